// ==== bench/e3ma_remote_term.sv ====
// Model of the remote E3 terminal and of the transmit framer facing the block.
`timescale 1ns/1ps
module e3ma_remote_term (
   input  wire logic       clk,      // System clock.
   input  wire logic       send,     // Present one incoming frame next cycle.
   input  wire logic [7:0] ma,       // Maintenance byte to present.
   input  wire logic [7:0] oper,     // Operator byte to present.
   input  wire logic [7:0] gen,      // General byte to present.
   input  wire logic       stall,    // Framer holds off the payload.
   output logic            rx_tick,  // Incoming overhead present.
   output logic      [7:0] rx_ma,    // Maintenance byte on the link.
   output logic      [7:0] rx_oper,  // Operator byte on the link.
   output logic      [7:0] rx_gen,   // General byte on the link.
   output logic            fr_ready  // Framer takes payload.
);
   // =========================================================================
   // Frame presentation.
   initial begin
      rx_tick = 1'b0;
   end
   // Between frames the bytes toggle, so a stale byte is never mistaken for a fresh one.
   always @(posedge clk) begin
      rx_tick <= send;
      rx_ma   <= send ? ma : ~rx_ma;
      rx_oper <= send ? oper : ~rx_oper;
      rx_gen  <= send ? gen : ~rx_gen;
   end
   assign fr_ready = ~stall;
endmodule

// ==== bench/tb_top.sv ====
// Self-checking testbench for the E3 maintenance and adaptation overhead block.
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
   $display("unexpected %s expected %0h seen %0h", nm, ex, got); end end
module tb_top;
   import e3ma_pkg::*;
   logic       clk = 1'b0, rst_n = 1'b0, reg_we = 1'b0, reg_re = 1'b0, tick = 1'b0;
   logic       defect = 1'b0, emm = 1'b0, mark = 1'b0, pinv = 1'b0, send = 1'b0, stall = 1'b0;
   logic       otake, gtake, rtick, rvo, rvg, pinr, poutv, poutr;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, dlo = 8'h00, dlg = 8'h00, pin = 8'h00;
   logic [7:0] sma = 8'h00, sop = 8'h00, sgn = 8'h00;
   logic [7:0] rdata, ma_o, op_o, gn_o, rdo, rdg, pout, rma, rop, rgn, rv;
   logic [1:0] mf = 2'h0, cur_mf;
   int         num_errors = 0, checks_done = 0;
   always #20 clk = ~clk;
   e3ma_overhead dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
      .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(rdata), .tx_frame_tick(tick),
      .rx_defect(defect), .rx_em_mismatch(emm), .tx_marker(mark), .tx_maint_adapt_byte(ma_o),
      .tx_operator_overhead_byte(op_o), .tx_general_channel_byte(gn_o),
      .tx_dl_oper_byte(dlo), .tx_dl_gen_byte(dlg), .tx_dl_oper_take(otake),
      .tx_dl_gen_take(gtake), .rx_frame_tick(rtick), .rx_maint_adapt_byte(rma),
      .rx_operator_overhead_byte(rop), .rx_general_channel_byte(rgn), .rx_dl_oper_byte(rdo),
      .rx_dl_oper_valid(rvo), .rx_dl_gen_byte(rdg), .rx_dl_gen_valid(rvg), .pl_in_data(pin),
      .pl_in_valid(pinv), .pl_in_ready(pinr), .pl_out_data(pout), .pl_out_valid(poutv),
      .pl_out_ready(poutr));
   e3ma_remote_term far_u (.clk(clk), .send(send), .ma(sma), .oper(sop), .gen(sgn),
      .stall(stall), .rx_tick(rtick), .rx_ma(rma), .rx_oper(rop), .rx_gen(rgn), .fr_ready(poutr));
   // =========================================================================
   // Bus and frame helpers.
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      reg_we <= 1'b1;
      @(posedge clk);
      reg_we <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      reg_re <= 1'b1;
      @(posedge clk);
      reg_re <= 1'b0;
      #1 d = rdata;
   endtask
   // The multiframe count is tracked here, one step per outbound frame.
   task automatic txf(input logic d, input logic e);
      @(posedge clk);
      tick <= 1'b1;
      defect <= d;
      emm <= e;
      @(posedge clk);
      tick <= 1'b0;
      emm <= 1'b0;
      #1 cur_mf = mf;
      mf = mf + 2'h1;
   endtask
   task automatic rxf(input logic [7:0] m, input logic [7:0] o, input logic [7:0] g);
      @(posedge clk);
      send <= 1'b1;
      sma <= m;
      sop <= o;
      sgn <= g;
      @(posedge clk);
      send <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // =========================================================================
   // Scenarios.
   task automatic t_reset;
      rd(ADDR_CTRL, rv);
      `CHK("ctrl", CTRL_RESET, rv)
      `CHK("tx ma", 8'h00, ma_o)
      wr(ADDR_RX_STAT, 8'hFF);
      rd(ADDR_RX_STAT, rv);
      `CHK("ro stat", 8'h00, rv)
      rd(4'hF, rv);
      `CHK("unmapped", 8'h00, rv)
      $display("test reset done");
   endtask
   task automatic t_ma_new;
      logic [3:0] ssm;
      logic [2:0] pt;
      logic [7:0] ex;
      ssm = 4'hA;
      wr(ADDR_TX_SSM, {4'h0, ssm});
      for (int i = 0; i < 8; i++) begin
         pt = {1'b0, i[1:0]};
         wr(ADDR_CTRL, {2'b00, pt, 3'b000});
         txf(i[0], 1'b0);
         ex = {i[0], 1'b0, pt, cur_mf, ssm[3 - cur_mf]};
         `CHK("tx ma", ex, ma_o)
      end
      $display("test ma new done");
   endtask
   task automatic t_rei;
      txf(1'b0, 1'b1);
      `CHK("rei same tick", 1'b0, ma_o[MA_REI_BIT])
      txf(1'b0, 1'b0);
      `CHK("rei next", 1'b1, ma_o[MA_REI_BIT])
      txf(1'b0, 1'b0);
      `CHK("rei clear", 1'b0, ma_o[MA_REI_BIT])
      $display("test rei done");
   endtask
   task automatic t_rx_ssm;
      logic [3:0] ssm;
      ssm = 4'h5;
      for (int m = 0; m < 4; m++) begin
         rxf({m == 3, 1'b0, PT_ATM, m[1:0], ssm[3 - m]}, 8'h00, 8'h00);
      end
      rd(ADDR_RX_SSM, rv);
      `CHK("rx ssm", 8'h05, rv)
      rd(ADDR_RX_STAT, rv);
      `CHK("rx stat", 8'h0A, rv)
      $display("test rx ssm done");
   endtask
   task automatic t_chan;
      wr(ADDR_TX_OPER, 8'h5A);
      wr(ADDR_TX_GEN, 8'hC3);
      txf(1'b0, 1'b0);
      `CHK("oper user", 8'h5A, op_o)
      `CHK("gen user", 8'hC3, gn_o)
      `CHK("oper take", 1'b0, otake)
      wr(ADDR_CTRL, 8'h0E);
      dlo <= 8'h81;
      dlg <= 8'h7E;
      txf(1'b0, 1'b0);
      `CHK("oper dl", {8'h81, 1'b1}, {op_o, otake})
      `CHK("gen dl", {8'h7E, 1'b1}, {gn_o, gtake})
      rxf(8'h00, 8'h3C, 8'h96);
      `CHK("rx oper dl", {8'h3C, 1'b1}, {rdo, rvo})
      `CHK("rx gen dl", {8'h96, 1'b1}, {rdg, rvg})
      wr(ADDR_CTRL, 8'h08);
      rxf(8'h00, 8'h24, 8'h42);
      `CHK("rx user valid", 1'b0, rvo | rvg)
      rd(ADDR_RX_GEN, rv);
      `CHK("rx gen user", 8'h42, rv)
      rd(ADDR_RX_OPER, rv);
      `CHK("rx oper user", 8'h24, rv)
      $display("test channels done");
   endtask
   task automatic t_old;
      wr(ADDR_CTRL, 8'h11);
      wr(ADDR_TX_SSM, 8'h2A);
      mark <= 1'b1;
      txf(1'b0, 1'b0);
      `CHK("old ma", 8'h15, ma_o)
      @(posedge clk);
      mark <= 1'b0;
      txf(1'b0, 1'b0);
      `CHK("old ma", 8'h14, ma_o)
      rxf(8'h07, 8'h00, 8'h00);
      rd(ADDR_RX_SSM, rv);
      `CHK("old rx ssm", 8'h35, rv)
      rd(ADDR_RX_STAT, rv);
      `CHK("old rx stat", 8'h20, rv)
      $display("test old layout done");
   endtask
   task automatic t_payload;
      @(posedge clk);
      pin <= 8'h11;
      pinv <= 1'b1;
      stall <= 1'b1;
      @(posedge clk);
      pin <= 8'h22;
      #1 `CHK("pl ready full", 1'b0, pinr)
      `CHK("pl first", {1'b1, 8'h11}, {poutv, pout})
      @(posedge clk);
      stall <= 1'b0;
      #1 `CHK("pl held", {1'b1, 8'h11}, {poutv, pout})
      @(posedge clk);
      pinv <= 1'b0;
      #1 `CHK("pl second", {1'b1, 8'h22}, {poutv, pout})
      @(posedge clk);
      #1 `CHK("pl empty", 1'b0, poutv)
      $display("test payload done");
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // The whole run needs about 120 cycles; the limit of 10000 cycles leaves ample margin.
   initial begin
      #400000;
      num_errors++;
      test_done();
   end
   initial begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_ma_new();
      t_rei();
      t_rx_ssm();
      t_chan();
      t_old();
      t_payload();
      test_done();
   end
endmodule

// ==== design/e3ma_ma_rx.sv ====
// Interprets the maintenance and adaptation byte of incoming frames.
`timescale 1ns/1ps
module e3ma_ma_rx
   import e3ma_pkg::*;
(
   input  wire logic       clk,          // System clock.
   input  wire logic       rst_n,        // Asynchronous reset, active low.
   input  wire logic       old_layout,   // High selects the older bit layout.
   input  wire logic       rx_tick,      // Incoming frame overhead present.
   input  wire logic [7:0] rx_ma,        // Incoming maintenance byte.
   output logic      [2:0] rx_ptype,     // Received payload type code.
   output logic            rx_rdi,       // Received remote defect bit.
   output logic            rx_rei,       // Received remote error bit.
   output logic            rx_marker,    // Received timing marker, older layout.
   output logic      [1:0] rx_pdep,      // Received payload dependent field.
   output logic      [3:0] rx_ssm        // Last complete status message.
);
   // ==========================================================================
   // Status message assembly.
   logic      [3:0] ssm_acc;
   wire logic [1:0] rx_mf    = rx_ma[MA_MF_HI:MA_MF_LO];
   wire logic [1:0] ssm_pos  = 2'(MF_LAST - rx_mf);
   wire logic       new_ssm  = rx_tick & ~old_layout;
   wire logic [3:0] next_acc = ssm_acc | (4'h1 << ssm_pos);
   wire logic [3:0] clr_acc  = ssm_acc & ~(4'h1 << ssm_pos);
   wire logic [3:0] upd_acc  = rx_ma[MA_SSM_BIT] ? next_acc : clr_acc;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_ptype  <= PT_UNEQUIPPED;
         rx_rdi    <= 1'b0;
         rx_rei    <= 1'b0;
         rx_marker <= 1'b0;
         rx_pdep   <= 2'h0;
         rx_ssm    <= 4'h0;
         ssm_acc   <= 4'h0;
      end else if (rx_tick) begin
         rx_ptype <= rx_ma[MA_PT_HI:MA_PT_LO];
         rx_rdi   <= rx_ma[MA_RDI_BIT];
         rx_rei   <= rx_ma[MA_REI_BIT];
         if (old_layout) begin
            rx_pdep   <= rx_mf;
            rx_marker <= rx_ma[MA_SSM_BIT];
         end
         if (new_ssm) begin
            ssm_acc <= upd_acc;
         end
         // The message is published only once bit 4 arrives, so software never
         // sees a mix of two different messages.
         if (new_ssm && rx_mf == MF_LAST) begin
            rx_ssm <= upd_acc;
         end
      end
   end
endmodule

// ==== design/e3ma_oh_chan.sv ====
// One operator or general channel overhead byte, user or data link source.
`timescale 1ns/1ps
module e3ma_oh_chan
   import e3ma_pkg::*;
(
   input  wire logic       clk,          // System clock.
   input  wire logic       rst_n,        // Asynchronous reset, active low.
   input  wire logic       dl_mode,      // High selects the data link message path.
   input  wire logic       tx_tick,      // Start of an outbound frame.
   input  wire logic [7:0] user_byte,    // Software byte for the user message.
   input  wire logic [7:0] dl_tx_byte,   // Byte offered by the data link source.
   output logic      [7:0] tx_byte,      // Byte placed in the outbound frame.
   output logic            dl_tx_take,   // Data link byte consumed this frame.
   input  wire logic       rx_tick,      // Incoming frame overhead present.
   input  wire logic [7:0] rx_byte_in,   // Byte from the incoming frame.
   output logic      [7:0] rx_byte,      // Last received byte.
   output logic      [7:0] dl_rx_byte,   // Received byte for the data link sink.
   output logic            dl_rx_valid   // Data link byte valid pulse.
);
   // ==========================================================================
   // Transmit and receive selection.
   wire logic [7:0] next_tx_byte = dl_mode ? dl_tx_byte : user_byte;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_byte     <= TX_OH_RESET;
         dl_tx_take  <= 1'b0;
         rx_byte     <= 8'h00;
         dl_rx_byte  <= 8'h00;
         dl_rx_valid <= 1'b0;
      end else begin
         dl_tx_take  <= tx_tick & dl_mode;
         dl_rx_valid <= rx_tick & dl_mode;
         if (tx_tick) begin
            tx_byte <= next_tx_byte;
         end
         if (rx_tick) begin
            rx_byte <= rx_byte_in;
         end
         if (rx_tick && dl_mode) begin
            dl_rx_byte <= rx_byte_in;
         end
      end
   end
endmodule

// ==== design/e3ma_overhead.sv ====
// E3 maintenance and adaptation overhead formatter, interpreter and payload stage.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
// Contract
// - Bits 3 to 5 carry payload type.
// - Codes 000,001,010,011 name payload kinds.
// - Status message sent one bit per frame.
// - Bits 6 and 7 are multiframe indicator.
// - Indicator 00 selects MSB, 11 LSB.
// - Older layout: payload dependent plus timing marker.
// - Operator byte carries user or data link.
// - General byte carries user or data link.
// - Payload input passes payload to framer.
// - Bit 1 set while receive defect.
// - Bit 2 set after error monitor mismatch.
module e3ma_overhead
   import e3ma_pkg::*;
(
   input  wire logic       clk,            // 25 MHz system clock.
   input  wire logic       rst_n,          // Asynchronous reset, active low.
   input  wire logic [3:0] reg_addr,       // Register index.
   input  wire logic [7:0] reg_wdata,      // Register write data.
   input  wire logic       reg_we,         // Write strobe.
   input  wire logic       reg_re,         // Read strobe.
   output logic      [7:0] reg_rdata,      // Read data, cycle after the strobe.
   input  wire logic       tx_frame_tick,  // Outbound frame overhead slot.
   input  wire logic       rx_defect,      // Receive LOS, LOF or AIS declared.
   input  wire logic       rx_em_mismatch, // Error monitor byte mismatch pulse.
   input  wire logic       tx_marker,      // Timing marker for the older layout.
   output logic      [7:0] tx_maint_adapt_byte,        // Outbound maintenance byte.
   output logic      [7:0] tx_operator_overhead_byte,  // Outbound operator byte.
   output logic      [7:0] tx_general_channel_byte,    // Outbound general byte.
   input  wire logic [7:0] tx_dl_oper_byte,  // Data link byte for operator slot.
   input  wire logic [7:0] tx_dl_gen_byte,   // Data link byte for general slot.
   output logic            tx_dl_oper_take,  // Operator data link byte consumed.
   output logic            tx_dl_gen_take,   // General data link byte consumed.
   input  wire logic       rx_frame_tick,    // Incoming overhead bytes present.
   input  wire logic [7:0] rx_maint_adapt_byte,        // Incoming maintenance byte.
   input  wire logic [7:0] rx_operator_overhead_byte,  // Incoming operator byte.
   input  wire logic [7:0] rx_general_channel_byte,    // Incoming general byte.
   output logic      [7:0] rx_dl_oper_byte,  // Operator byte to data link sink.
   output logic            rx_dl_oper_valid, // Operator data link byte pulse.
   output logic      [7:0] rx_dl_gen_byte,   // General byte to data link sink.
   output logic            rx_dl_gen_valid,  // General data link byte pulse.
   input  wire logic [7:0] pl_in_data,     // Payload byte from the system side.
   input  wire logic       pl_in_valid,    // Payload byte valid.
   output logic            pl_in_ready,    // Payload stage can accept.
   output logic      [7:0] pl_out_data,    // Payload byte to the framer.
   output logic            pl_out_valid,   // Payload byte to framer valid.
   input  wire logic       pl_out_ready    // Framer takes the payload byte.
);
   // ==========================================================================
   // Software registers.
   logic [7:0] ctrl;
   logic [7:0] tx_ssm_reg;
   logic [7:0] tx_oper_user;
   logic [7:0] tx_gen_user;

   wire logic       old_layout = ctrl[CTRL_OLD_LAYOUT];
   wire logic       oper_dl    = ctrl[CTRL_OPER_DL];
   wire logic       gen_dl     = ctrl[CTRL_GEN_DL];
   wire logic [2:0] tx_ptype   = ctrl[CTRL_PT_HI:CTRL_PT_LO];
   wire logic [3:0] tx_ssm     = tx_ssm_reg[3:0];
   wire logic [1:0] tx_pdep    = tx_ssm_reg[5:4];

   wire logic wr_ctrl = reg_we && reg_addr == ADDR_CTRL;
   wire logic wr_ssm  = reg_we && reg_addr == ADDR_TX_SSM;
   wire logic wr_oper = reg_we && reg_addr == ADDR_TX_OPER;
   wire logic wr_gen  = reg_we && reg_addr == ADDR_TX_GEN;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl         <= CTRL_RESET;
         tx_ssm_reg   <= TX_SSM_RESET;
         tx_oper_user <= TX_OH_RESET;
         tx_gen_user  <= TX_OH_RESET;
      end else begin
         if (wr_ctrl) ctrl <= reg_wdata;
         if (wr_ssm) tx_ssm_reg <= reg_wdata;
         if (wr_oper) tx_oper_user <= reg_wdata;
         if (wr_gen) tx_gen_user <= reg_wdata;
      end
   end

   // ==========================================================================
   // Outbound maintenance and adaptation byte.
   logic [1:0] mf_cnt;
   logic       rei_pend;

   // A mismatch seen in the overhead slot cycle itself is kept for the next frame.
   wire logic       next_rei_pend = rx_em_mismatch | (rei_pend & ~tx_frame_tick);
   wire logic [1:0] ssm_pos       = 2'(MF_LAST - mf_cnt);
   wire logic       ssm_bit       = tx_ssm[ssm_pos];
   wire logic [1:0] mf_field      = old_layout ? tx_pdep : mf_cnt;
   wire logic       last_bit      = old_layout ? tx_marker : ssm_bit;
   wire logic [7:0] next_ma       = {rx_defect, rei_pend, tx_ptype,
                                     mf_field, last_bit};

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mf_cnt              <= MF_FIRST;
         rei_pend            <= 1'b0;
         tx_maint_adapt_byte <= 8'h00;
      end else begin
         rei_pend <= next_rei_pend;
         if (tx_frame_tick) begin
            tx_maint_adapt_byte <= next_ma;
            mf_cnt              <= 2'(mf_cnt + 2'h1);
         end
      end
   end

   // ==========================================================================
   // Operator and general channel bytes.
   logic [7:0] rx_oper;
   logic [7:0] rx_gen;

   e3ma_oh_chan u_oper (
      .clk         (clk),
      .rst_n       (rst_n),
      .dl_mode     (oper_dl),
      .tx_tick     (tx_frame_tick),
      .user_byte   (tx_oper_user),
      .dl_tx_byte  (tx_dl_oper_byte),
      .tx_byte     (tx_operator_overhead_byte),
      .dl_tx_take  (tx_dl_oper_take),
      .rx_tick     (rx_frame_tick),
      .rx_byte_in  (rx_operator_overhead_byte),
      .rx_byte     (rx_oper),
      .dl_rx_byte  (rx_dl_oper_byte),
      .dl_rx_valid (rx_dl_oper_valid)
   );

   e3ma_oh_chan u_gen (
      .clk         (clk),
      .rst_n       (rst_n),
      .dl_mode     (gen_dl),
      .tx_tick     (tx_frame_tick),
      .user_byte   (tx_gen_user),
      .dl_tx_byte  (tx_dl_gen_byte),
      .tx_byte     (tx_general_channel_byte),
      .dl_tx_take  (tx_dl_gen_take),
      .rx_tick     (rx_frame_tick),
      .rx_byte_in  (rx_general_channel_byte),
      .rx_byte     (rx_gen),
      .dl_rx_byte  (rx_dl_gen_byte),
      .dl_rx_valid (rx_dl_gen_valid)
   );

   // ==========================================================================
   // Incoming maintenance byte.
   logic [2:0] rx_ptype;
   logic       rx_rdi;
   logic       rx_rei;
   logic       rx_marker;
   logic [1:0] rx_pdep;
   logic [3:0] rx_ssm;

   e3ma_ma_rx u_ma_rx (
      .clk        (clk),
      .rst_n      (rst_n),
      .old_layout (old_layout),
      .rx_tick    (rx_frame_tick),
      .rx_ma      (rx_maint_adapt_byte),
      .rx_ptype   (rx_ptype),
      .rx_rdi     (rx_rdi),
      .rx_rei     (rx_rei),
      .rx_marker  (rx_marker),
      .rx_pdep    (rx_pdep),
      .rx_ssm     (rx_ssm)
   );

   // ==========================================================================
   // Register read path.
   wire logic [7:0] rx_stat = {2'h0, rx_marker, rx_rei, rx_rdi, rx_ptype};
   wire logic [7:0] rx_ssmr = {2'h0, rx_pdep, rx_ssm};
   logic      [7:0] rd_mux;

   always_comb begin
      case (reg_addr)
         ADDR_CTRL:    rd_mux = ctrl;
         ADDR_TX_SSM:  rd_mux = tx_ssm_reg;
         ADDR_TX_OPER: rd_mux = tx_oper_user;
         ADDR_TX_GEN:  rd_mux = tx_gen_user;
         ADDR_RX_STAT: rd_mux = rx_stat;
         ADDR_RX_SSM:  rd_mux = rx_ssmr;
         ADDR_RX_OPER: rd_mux = rx_oper;
         ADDR_RX_GEN:  rd_mux = rx_gen;
         default:      rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else begin
         reg_rdata <= reg_re ? rd_mux : 8'h00;
      end
   end

   // ==========================================================================
   // Transmit payload input stage: one holding register, so the framer can stall
   // the system side without losing a byte.
   wire logic pl_take = pl_in_valid & pl_in_ready;
   assign pl_in_ready = ~pl_out_valid | pl_out_ready;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pl_out_valid <= 1'b0;
         pl_out_data  <= 8'h00;
      end else begin
         if (pl_take) begin
            pl_out_data <= pl_in_data;
         end
         if (pl_in_ready) begin
            pl_out_valid <= pl_in_valid;
         end
      end
   end

   // ==========================================================================
   // Checks.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_tick_new;
      tx_frame_tick && !old_layout;
   endsequence

   // A frame slot in which the pending remote error is due to go out.
   sequence s_rei_due;
      tx_frame_tick && rei_pend;
   endsequence

   AST_PTYPE: assert property (tx_frame_tick
         |=> tx_maint_adapt_byte[5:3] == $past(tx_ptype))
      else $error("Payload type field differs from the configured code.");

   AST_PT_CODES: assert property (rx_frame_tick && rx_maint_adapt_byte[5:3] == PT_ATM
         |=> rx_ptype == PT_ATM)
      else $error("Received ATM payload code not reported.");

   AST_SSM_BIT: assert property (s_tick_new |=> tx_maint_adapt_byte[0]
         == $past(tx_ssm[2'(MF_LAST - mf_cnt)]))
      else $error("Status message bit does not match the indicator.");

   AST_MF_STEP: assert property (s_tick_new |=> mf_cnt == 2'($past(mf_cnt) + 2'h1)
         && tx_maint_adapt_byte[2:1] == $past(mf_cnt))
      else $error("Multiframe indicator did not advance by one.");

   AST_MF_MSB: assert property (s_tick_new ##0 mf_cnt == MF_FIRST
         |=> tx_maint_adapt_byte[2:0] == {2'h0, $past(tx_ssm[3])})
      else $error("Indicator 00 does not carry the most significant bit.");

   AST_OLD_LAYOUT: assert property (tx_frame_tick && old_layout
         |=> tx_maint_adapt_byte[2:0] == {$past(tx_pdep), $past(tx_marker)})
      else $error("Older layout bits 6 to 8 are wrong.");

   AST_OPER_SRC: assert property (tx_frame_tick |=> tx_operator_overhead_byte
         == $past(oper_dl ? tx_dl_oper_byte : tx_oper_user))
      else $error("Operator byte source selection is wrong.");

   AST_GEN_SRC: assert property (tx_frame_tick |=> tx_general_channel_byte
         == $past(gen_dl ? tx_dl_gen_byte : tx_gen_user) && tx_dl_gen_take == $past(gen_dl))
      else $error("General byte source selection is wrong.");

   AST_PL_HOLD: assert property (pl_out_valid && !pl_out_ready
         |=> pl_out_valid && $stable(pl_out_data))
      else $error("Payload byte dropped while the framer stalls.");

   AST_PL_PASS: assert property (pl_in_valid && pl_in_ready
         |=> pl_out_valid && pl_out_data == $past(pl_in_data))
      else $error("Accepted payload byte not passed to the framer.");

   AST_RDI: assert property (tx_frame_tick
         |=> tx_maint_adapt_byte[7] == $past(rx_defect))
      else $error("Remote defect bit does not follow the receive defect.");

   AST_REI_PEND: assert property (rx_em_mismatch |=> rei_pend)
      else $error("Mismatch not kept for the next outbound byte.");

   AST_REI_SET: assert property (s_rei_due |=> tx_maint_adapt_byte[6])
      else $error("Mismatch not reported in the next outbound byte.");

   AST_REI_CLR: assert property (tx_frame_tick && !rei_pend
         |=> !tx_maint_adapt_byte[6])
      else $error("Remote error bit set with no mismatch.");

   AST_RD_IDLE: assert property (!reg_re |=> reg_rdata == 8'h00)
      else $error("Read data present without a read strobe.");
endmodule

// ==== design/e3ma_pkg.sv ====
// Constants shared by the E3 maintenance and adaptation overhead block.
package e3ma_pkg;
   // ==========================================================================
   // Register map, index on the plain register port.
   localparam logic [3:0] ADDR_CTRL    = 4'h0;
   localparam logic [3:0] ADDR_TX_SSM  = 4'h1;
   localparam logic [3:0] ADDR_TX_OPER = 4'h2;
   localparam logic [3:0] ADDR_TX_GEN  = 4'h3;
   localparam logic [3:0] ADDR_RX_STAT = 4'h4;
   localparam logic [3:0] ADDR_RX_SSM  = 4'h5;
   localparam logic [3:0] ADDR_RX_OPER = 4'h6;
   localparam logic [3:0] ADDR_RX_GEN  = 4'h7;

   // ==========================================================================
   // Control register fields.
   localparam int CTRL_OLD_LAYOUT = 0;
   localparam int CTRL_OPER_DL    = 1;
   localparam int CTRL_GEN_DL     = 2;
   localparam int CTRL_PT_LO      = 3;
   localparam int CTRL_PT_HI      = 5;
   localparam logic [7:0] CTRL_RESET   = 8'h08;
   localparam logic [7:0] TX_SSM_RESET = 8'h00;
   localparam logic [7:0] TX_OH_RESET  = 8'h00;

   // ==========================================================================
   // Overhead byte bit positions; bit 1 of the byte is the MSB sent first.
   localparam int MA_RDI_BIT = 7;
   localparam int MA_REI_BIT = 6;
   localparam int MA_PT_HI   = 5;
   localparam int MA_PT_LO   = 3;
   localparam int MA_MF_HI   = 2;
   localparam int MA_MF_LO   = 1;
   localparam int MA_SSM_BIT = 0;

   // ==========================================================================
   // Payload type codes and multiframe indicator values.
   localparam logic [2:0] PT_UNEQUIPPED  = 3'h0;
   localparam logic [2:0] PT_EQUIPPED_NS = 3'h1;
   localparam logic [2:0] PT_ATM         = 3'h2;
   localparam logic [2:0] PT_TU12       = 3'h3;
   localparam logic [1:0] MF_FIRST       = 2'h0;
   localparam logic [1:0] MF_LAST        = 2'h3;
endpackage
